/* File: rtl/adcis_pkg.sv */
// adcis_pkg: register map, field layout and state type of the converter
// control slice; assumes a 16-bit byte address on the register port.
package adcis_pkg;

  localparam int ADDR_W = 16;
  localparam int N_CAL  = 6;
  localparam int N_CORE = 6;

  // calibration words for converters 1,2,3,4,5,7
  localparam logic [15:0] CAL_OFF [N_CAL] = '{16'h7d10, 16'h7d20, 16'h7d30,
                                              16'h7d40, 16'h7d50, 16'h7d70};
  localparam logic [31:0] CAL_RST = 32'h0000_0000;

  // per-input interrupt enables, inputs 33..41 and 45..53 at bits 1..9 and 13..21
  localparam logic [15:0] IRQEN_OFF  = 16'h7d80;
  localparam logic [31:0] IRQEN_MASK = 32'h003f_e3fe;
  localparam logic [31:0] IRQEN_RST  = 32'h0000_0000;

  // global mode bits
  localparam logic [15:0] CFG_OFF      = 16'h7d84;
  localparam int          CFG_CVD_BIT  = 0;
  localparam int          CFG_FRACTIONAL_FORMAT_SELECT_BIT = 1;
  localparam int          CFG_TRG3_BIT = 2;
  localparam int          CFG_FEN_LSB  = 8;
  localparam int          CFG_FMODE_LSB = 16;
  localparam logic [31:0] CFG_MASK     = 32'h003f_3f07;
  localparam logic [31:0] CFG_RST      = 32'h0000_0000;

  // digital comparator 1 control
  localparam logic [15:0] CMP_OFF     = 16'h7d88;
  localparam int          CMP_DATA_LSB = 16;
  localparam int          CMP_ID_LSB  = 8;
  localparam int          CMP_ED_BIT  = 5;
  localparam logic [31:0] CMP_WR_MASK = 32'h0000_00df;
  localparam logic [31:0] CMP_RST     = 32'h0000_0000;

  // dedicated core timing, one word per core
  localparam logic [15:0] TIME_OFF0   = 16'h7d90;
  localparam int          TIME_STRIDE = 4;
  localparam int          SAMPLE_TIME_COUNT_LSB    = 0;
  localparam int          SAMPLE_TIME_COUNT_W      = 10;
  localparam int          DIV_LSB     = 16;
  localparam int          DIV_W       = 7;
  localparam logic [31:0] TIME_MASK   = 32'h007f_03ff;
  localparam logic [31:0] TIME_RST    = 32'h0000_0000;
  // encoding zero already means two conversion clock periods
  localparam logic [SAMPLE_TIME_COUNT_W:0] SAMPLE_TIME_COUNT_EXTRA = 11'h002;

  typedef enum logic [1:0] {
    CORE_IDLE,
    CORE_SAMPLE,
    CORE_CONVERT
  } adcis_core_state_t;

endpackage

/* File: rtl/adcis_ctrl.sv */
// adcis_ctrl: calibration words, per-input interrupt gating, capacitive
// difference capture and dedicated-core sample timing.
// assumes result-ready, comparator, trigger and done inputs are on clk.
`timescale 1ns/1ps

module adcis_ctrl
  import adcis_pkg::*;
#(
  parameter int RES_W = 12
)(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  output logic      [31:0]         calibration_word [N_CAL],
  input  wire logic [31:0]         input_result_ready,
  output logic      [31:0]         input_irq,
  input  wire logic                cmp_event,
  input  wire logic [RES_W-1:0]    cvd_positive,
  input  wire logic [RES_W-1:0]    cvd_negative,
  input  wire logic [5:0]          input_identifier,
  input  wire logic [N_CORE-1:0]   core_enable,
  input  wire logic [N_CORE-1:0]   core_trigger,
  input  wire logic [N_CORE-1:0]   core_convert_done,
  output logic      [N_CORE-1:0]   core_sampling,
  output logic      [N_CORE-1:0]   core_convert_start
);

  logic [31:0]        cal_q [N_CAL];
  logic [31:0]        irqen_q;
  logic [31:0]        cfg_q;
  logic [31:0]        cmp_q;
  logic [31:0]        time_q [N_CORE];
  logic [31:0]        rdata_d;
  logic [31:0]        irq_q;
  logic signed [RES_W:0] cvd_diff;
  logic [15:0]        cvd_fmt;

  // calibration words: plain storage, handed on untouched
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int k = 0; k < N_CAL; k++)
        cal_q[k] <= CAL_RST;
    end
    else if (reg_wr)
    begin
      for (int k = 0; k < N_CAL; k++)
        if (reg_addr == CAL_OFF[k])
          cal_q[k] <= reg_wdata;
    end
  end

  assign calibration_word = cal_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irqen_q <= IRQEN_RST;
    else if (reg_wr && reg_addr == IRQEN_OFF)
      irqen_q <= reg_wdata & IRQEN_MASK;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_q <= CFG_RST;
    else if (reg_wr && reg_addr == CFG_OFF)
      cfg_q <= reg_wdata & CFG_MASK;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int k = 0; k < N_CORE; k++)
        time_q[k] <= TIME_RST;
    end
    else if (reg_wr)
    begin
      for (int k = 0; k < N_CORE; k++)
        if (reg_addr == TIME_OFF0 + 16'(k * TIME_STRIDE))
          time_q[k] <= reg_wdata & TIME_MASK;
    end
  end

  // interrupt per input: enabled and result ready
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_q <= 32'h0000_0000;
    else
      irq_q <= irqen_q & input_result_ready & IRQEN_MASK;
  end

  assign input_irq = irq_q;

  // difference of the two measurements, one bit wider so it never wraps
  assign cvd_diff = $signed({1'b0, cvd_positive})
                  - $signed({1'b0, cvd_negative});

  // fractional puts the sign at bit 15; integer sign-extends
  always_comb
  begin
    if (cfg_q[CFG_FRACTIONAL_FORMAT_SELECT_BIT])
      cvd_fmt = {cvd_diff, {(15 - RES_W){1'b0}}};
    else
      cvd_fmt = 16'(cvd_diff);
  end

  // comparator control: data and id captured by hardware, event flag
  // cleared by reading; a new event in the read cycle keeps the flag
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cmp_q <= CMP_RST;
    else
    begin
      if (reg_wr && reg_addr == CMP_OFF)
        cmp_q[7:0] <= (reg_wdata[7:0] & CMP_WR_MASK[7:0])
                    | (cmp_q[7:0] & ~CMP_WR_MASK[7:0]);
      if (reg_rd && reg_addr == CMP_OFF)
        cmp_q[CMP_ED_BIT] <= 1'b0;
      if (cmp_event)
      begin
        cmp_q[CMP_ED_BIT] <= 1'b1;
        cmp_q[CMP_ID_LSB +: 6] <= input_identifier;
        if (cfg_q[CFG_CVD_BIT])
          cmp_q[CMP_DATA_LSB +: 16] <= cvd_fmt;
      end
    end
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    for (int k = 0; k < N_CAL; k++)
      if (reg_addr == CAL_OFF[k])
        rdata_d = cal_q[k];
    for (int k = 0; k < N_CORE; k++)
      if (reg_addr == TIME_OFF0 + 16'(k * TIME_STRIDE))
        rdata_d = time_q[k];
    if (reg_addr == IRQEN_OFF)
      rdata_d = irqen_q & IRQEN_MASK;
    if (reg_addr == CFG_OFF)
      rdata_d = cfg_q;
    if (reg_addr == CMP_OFF)
      rdata_d = cmp_q;
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 32'h0000_0000;
  end

  generate
    for (genvar i = 0; i < N_CORE; i++)
    begin : g_core
      adcis_core_state_t state_q;
      logic [DIV_W-1:0]  div_cnt_q;
      logic [SAMPLE_TIME_COUNT_W:0]   tad_cnt_q;
      logic [SAMPLE_TIME_COUNT_W:0]   target;
      logic              tick;
      logic              expired;
      logic              auto_go;
      logic              go;
      logic              pend_q;
      logic              start_q;
      logic [19:0]       samp_cyc_q;
      logic [19:0]       min_cyc;

      assign target  = {1'b0, time_q[i][SAMPLE_TIME_COUNT_LSB +: SAMPLE_TIME_COUNT_W]}
                     + SAMPLE_TIME_COUNT_EXTRA;
      // one period of the divided clock is div+1 system clocks
      assign tick    = div_cnt_q == time_q[i][DIV_LSB +: DIV_W];
      assign expired = tad_cnt_q >= target;
      assign auto_go = (cfg_q[CFG_FEN_LSB + i]
                       && !cfg_q[CFG_FMODE_LSB + i])
                     || cfg_q[CFG_TRG3_BIT];
      assign go      = pend_q || core_trigger[i] || auto_go;

      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          state_q <= CORE_IDLE;
        else
        begin
          unique case (state_q)
            CORE_IDLE:
              if (core_enable[i])
                state_q <= CORE_SAMPLE;
            CORE_SAMPLE:
              if (!core_enable[i])
                state_q <= CORE_IDLE;
              else if (expired && go)
                state_q <= CORE_CONVERT;
            CORE_CONVERT:
              if (!core_enable[i])
                state_q <= CORE_IDLE;
              else if (core_convert_done[i])
                state_q <= CORE_SAMPLE;
          endcase
        end
      end

      // counters restart on every entry to sampling
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          div_cnt_q <= '0;
          tad_cnt_q <= '0;
        end
        else if (state_q != CORE_SAMPLE)
        begin
          div_cnt_q <= '0;
          tad_cnt_q <= '0;
        end
        else if (tick)
        begin
          div_cnt_q <= '0;
          if (!expired)
            tad_cnt_q <= tad_cnt_q + 11'h001;
        end
        else
          div_cnt_q <= div_cnt_q + 7'h01;
      end

      // an early trigger is remembered until sampling ends
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          pend_q <= 1'b0;
        else
          pend_q <= state_q == CORE_SAMPLE && core_enable[i]
                    && !(expired && go)
                    && (pend_q || core_trigger[i]);
      end

      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          start_q <= 1'b0;
        else
          start_q <= state_q == CORE_SAMPLE && core_enable[i]
                     && expired && go;
      end

      assign core_sampling[i]      = state_q == CORE_SAMPLE;
      assign core_convert_start[i] = start_q;

      // helper for the checks: system clocks spent sampling
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          samp_cyc_q <= '0;
        else if (state_q == CORE_SAMPLE)
          samp_cyc_q <= samp_cyc_q + 20'h00001;
        else if (!start_q)
          samp_cyc_q <= '0;
      end

      // widened before the product: 1025 periods of 128 clocks overflow
      // the eleven-bit target
      assign min_cyc = 20'(target)
                     * (20'(time_q[i][DIV_LSB +: DIV_W]) + 20'h00001);

      sample_min_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        start_q |-> samp_cyc_q >= min_cyc)
        else $error("conversion started before sample time");

      pending_go_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        state_q == CORE_SAMPLE && core_enable[i] && expired && pend_q
        |=> start_q && state_q == CORE_CONVERT)
        else $error("pending trigger not acted on");

      hold_sample_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        state_q == CORE_SAMPLE && core_enable[i] && expired && !go
        |=> state_q == CORE_SAMPLE && !start_q)
        else $error("left sampling without trigger");

      auto_conv_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        state_q == CORE_SAMPLE && core_enable[i] && expired && auto_go
        |=> start_q)
        else $error("no automatic conversion at expiry");

      zero_two_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        state_q == CORE_SAMPLE && time_q[i][DIV_LSB +: DIV_W] == 7'h00
        && time_q[i][SAMPLE_TIME_COUNT_LSB +: SAMPLE_TIME_COUNT_W] == 10'h000 && tad_cnt_q == '0
        && core_enable[i] |=> !expired)
        else $error("zero sample time shorter than two periods");
    end
  endgenerate

  sequence cvd_capture_s;
    cmp_event && cfg_q[CFG_CVD_BIT];
  endsequence

  cvd_capture_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    cvd_capture_s |=> cmp_q[CMP_DATA_LSB +: 16] == $past(cvd_fmt))
    else $error("difference not captured");

  cvd_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !cmp_event |=> $stable(cmp_q[CMP_DATA_LSB +: 16]))
    else $error("difference changed without event");

  cvd_sign_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    cvd_capture_s and (cvd_positive < cvd_negative)
    |=> cmp_q[31])
    else $error("negative difference lost its sign");

  irq_gate_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 input_irq == ($past(irqen_q) & $past(input_result_ready)
                      & IRQEN_MASK))
    else $error("interrupt not gated by enable");

  unimpl_zero_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == IRQEN_OFF |=> (reg_rdata & ~IRQEN_MASK) == '0)
    else $error("unimplemented enable bits read nonzero");

  cal_fwd_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == CAL_OFF[0]
    |=> calibration_word[0] == $past(reg_wdata))
    else $error("calibration word not forwarded");

endmodule

/* File: sim/tb.sv */
// tb: self-checking bench for adcis_ctrl, driving every port directly
// assumes the register port answers reads one cycle after the strobe
`timescale 1ns/1ps

module tb
  import adcis_pkg::*;
;
  localparam int RW = 12;
  logic              clk;
  logic              reset_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic [31:0]       calibration_word [N_CAL];
  logic [31:0]       input_result_ready;
  logic [31:0]       input_irq;
  logic              cmp_event;
  logic [RW-1:0]     cvd_positive;
  logic [RW-1:0]     cvd_negative;
  logic [5:0]        input_identifier;
  logic [N_CORE-1:0] core_enable;
  logic [N_CORE-1:0] core_trigger;
  logic [N_CORE-1:0] core_convert_done;
  logic [N_CORE-1:0] core_sampling;
  logic [N_CORE-1:0] core_convert_start;
  int                fail_count;
  int                checks_done;
  logic [31:0]       seed;
  logic [31:0]       rd;
  logic [31:0]       cal [N_CAL];
  logic [31:0]       en;
  logic [15:0]       prev;
  // non-calibration registers, incl. each core's timing word
  logic [15:0] cfgs_a [9] = '{IRQEN_OFF, CFG_OFF, CMP_OFF, TIME_OFF0,
                              16'h7d94, 16'h7d98, 16'h7d9c, 16'h7da0,
                              16'h7da4};

  adcis_ctrl #(.RES_W(RW)) DUT (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .calibration_word(calibration_word),
    .input_result_ready(input_result_ready), .input_irq(input_irq),
    .cmp_event(cmp_event), .cvd_positive(cvd_positive),
    .cvd_negative(cvd_negative), .input_identifier(input_identifier),
    .core_enable(core_enable), .core_trigger(core_trigger),
    .core_convert_done(core_convert_done), .core_sampling(core_sampling),
    .core_convert_start(core_convert_start)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // signed difference, either sign-extended or left-justified to 16 bits
  function automatic logic [15:0] cvd_exp(input logic [RW-1:0] p,
                                          input logic [RW-1:0] n,
                                          input logic          fr);
    logic [RW:0] d;
    d = {1'b0, p} - {1'b0, n};
    return fr ? {d, {(15 - RW){1'b0}}} : {{(15 - RW){d[RW]}}, d};
  endfunction

  function automatic int samp_exp(input int c, input int d);
    return (c + 2) * (d + 1) + 1;
  endfunction

  task automatic rnd(output logic [31:0] v);
    seed = lfsr_next(seed);
    v = seed;
  endtask

  task automatic conclude();
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    checks_done++;
    if (e !== g)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int e, input int g);
    checks_done++;
    if (e != g)
    begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rdr(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic cmp_fire(input logic fr, input logic cvd_on);
    logic [31:0] r;
    logic [15:0] e;
    rnd(r);
    wr(CFG_OFF, {30'h0, fr, cvd_on});
    @(posedge clk);
    cvd_positive     <= r[11:0];
    cvd_negative     <= r[27:16];
    input_identifier <= r[31:26];
    cmp_event        <= 1'b1;
    @(posedge clk);
    cmp_event <= 1'b0;
    e = cvd_on ? cvd_exp(r[11:0], r[27:16], fr) : prev;
    rdr(CMP_OFF, rd);
    chk_val("cvd_result", e, rd[31:16]);
    chk_val("input_id", r[31:26], rd[13:8]);
    chk_val("event_flag", 1, rd[CMP_ED_BIT]);
    prev = rd[31:16];
    rdr(CMP_OFF, rd);
    chk_val("event_clear", 0, rd[CMP_ED_BIT]);
    chk_val("cvd_kept", prev, rd[31:16]);
  endtask

  // mode 0 early trigger, 1 filter auto, 2 level trigger auto, 3 waits
  task automatic run_core(input int mode, input int q);
    logic [31:0] r;
    int          c;
    int          d;
    int          n;
    int          lim;
    logic [15:0] ta;
    logic [31:0] cfgs [4];
    cfgs = '{32'h0, 32'h0000_0100 << q, 32'h4, 32'h0001_0100 << q};
    rnd(r);
    c = r[2:0];
    d = r[5:4];
    ta = TIME_OFF0 + 16'(q * TIME_STRIDE);
    wr(ta, {9'h0, 7'(d), 6'h0, 10'(c)});
    wr(CFG_OFF, cfgs[mode]);
    @(posedge clk);
    core_enable[q] <= 1'b1;
    n = 0;
    while (core_sampling[q] !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    lim = (mode == 3) ? samp_exp(c, d) + 8 : 300;
    while (core_convert_start[q] !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      core_trigger[q] <= (mode == 0 && n == 0);
      #1;
      n++;
    end
    if (mode == 3)
    begin
      chk_cnt("wait_no_start", lim, n);
      chk_val("still_sampling", 1, core_sampling[q]);
      n = 0;
      while (core_convert_start[q] !== 1'b1 && n < 4)
      begin
        @(posedge clk);
        core_trigger[q] <= (n == 0);
        #1;
        n++;
      end
      chk_cnt("late_trigger", 1, int'(n < 4));
    end
    else
      chk_cnt("sample", samp_exp(c, d), n);
    @(posedge clk);
    core_trigger[q] <= 1'b0;
    #1;
    chk_val("sampling_off", 0, core_sampling[q]);
    @(posedge clk);
    core_convert_done[q] <= 1'b1;
    @(posedge clk);
    core_convert_done[q] <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_val("resample", 1, core_sampling[q]);
    @(posedge clk);
    core_enable[q] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial
  begin
    #200us;
    fail_count++;
    conclude();
  end

  initial
  begin
    seed = 32'h827219f4;
    prev = 16'h0;
    reset_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, cmp_event} = '0;
    {input_result_ready, cvd_positive, cvd_negative} = '0;
    {input_identifier, core_enable, core_trigger} = '0;
    core_convert_done = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < N_CAL; i++)
    begin
      rdr(CAL_OFF[i], rd);
      chk_val("cal_reset", CAL_RST, rd);
      chk_val("cal_out_reset", CAL_RST, calibration_word[i]);
    end
    foreach (cfgs_a[k])
    begin
      rdr(cfgs_a[k], rd);
      chk_val("reg_reset", 32'h0, rd);
    end
    rdr(16'h7d60, rd);
    chk_val("unmapped", 32'h0, rd);
    // calibration load before any conversion work
    for (int i = 0; i < N_CAL; i++)
    begin
      rnd(cal[i]);
      wr(CAL_OFF[i], cal[i]);
    end
    wr(16'h7d60, 32'hffff_ffff);
    for (int i = 0; i < N_CAL; i++)
    begin
      rdr(CAL_OFF[i], rd);
      chk_val("cal_read", cal[i], rd);
      chk_val("cal_out", cal[i], calibration_word[i]);
    end
    wr(IRQEN_OFF, 32'hffff_ffff);
    rdr(IRQEN_OFF, rd);
    chk_val("irqen_mask", 32'h003f_e3fe, rd);
    for (int k = 0; k < 6; k++)
    begin
      rnd(en);
      if (k == 0)
        en = 32'h0;
      wr(IRQEN_OFF, en);
      rnd(rd);
      @(posedge clk);
      input_result_ready <= rd;
      repeat (2) @(posedge clk);
      #1;
      chk_val("input_irq", en & rd & 32'h003f_e3fe, input_irq);
    end
    for (int k = 0; k < 6; k++)
      cmp_fire(k[0], k != 4);
    for (int m = 0; m < 4; m++)
      for (int j = 0; j < 3; j++)
        run_core(m, (m * 3 + j) % N_CORE);
    conclude();
  end

endmodule
